/* pic_counter.sv */
// Three-channel programmable interval down-counter with register port.
// Assumes gate and external clock pins are asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module pic_counter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [pic_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pic_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pic_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [pic_pkg::NUM_CNT-1:0] gate_in,
    input wire logic [pic_pkg::NUM_CNT-1:0] external_count_clock,
    input wire logic counter10_in,
    output logic [pic_pkg::NUM_CNT-1:0] counter_output
);
    import pic_pkg::*;

    typedef struct packed {
        pic_chan_s [NUM_CNT-1:0] ch;
        logic [NUM_CNT-1:0] gate_s1;
        logic [NUM_CNT-1:0] gate_s2;
        logic [NUM_CNT-1:0] eclk_s1;
        logic [NUM_CNT-1:0] eclk_s2;
        logic [NUM_CNT-1:0] eclk_d;
        logic c10_s1;
        logic c10_s2;
        logic c10_d;
        logic [NUM_CNT-1:0] prev_d;
        logic [NUM_CNT-1:0] trig;
        logic [7:0] div;
        logic [CNT_W-1:0] rb;
        logic [DATA_W-1:0] rdata;
    } pic_state_s;

    pic_state_s st_r;
    pic_state_s st_nxt;

    function automatic logic [CNT_W-1:0] pic_dec(input logic [CNT_W-1:0] v, input logic dec);
        logic [CNT_W-1:0] r;
        r = v - 16'h0001;
        if (dec) begin
            r = v;
            for (int d = 0; d < 4; d++) begin
                if (r[4*d +: 4] != 4'h0) begin
                    r[4*d +: 4] = r[4*d +: 4] - 4'h1;
                    break;
                end
                r[4*d +: 4] = 4'h9;
            end
        end
        return r;
    endfunction : pic_dec

    // Zero load stands for the full range
    function automatic logic [CNT_W-1:0] pic_full(input logic [CNT_W-1:0] v, input logic dec);
        logic [CNT_W-1:0] r;
        r = v;
        if (v == 16'h0000) begin
            r = dec ? 16'h9999 : 16'hFFFF;
        end
        return r;
    endfunction : pic_full

    always_comb begin
        logic int_tick;
        logic c10_edge;
        logic tick;
        logic [2:0] op;
        logic [CNT_W-1:0] nxt;
        logic gate_rise;
        int_tick = 1'b0;
        c10_edge = 1'b0;
        tick = 1'b0;
        op = 3'h0;
        nxt = 16'h0000;
        gate_rise = 1'b0;
        st_nxt = st_r;
        st_nxt.gate_s1 = gate_in;
        st_nxt.gate_s2 = st_r.gate_s1;
        st_nxt.eclk_s1 = external_count_clock;
        st_nxt.eclk_s2 = st_r.eclk_s1;
        st_nxt.eclk_d = st_r.eclk_s2;
        st_nxt.c10_s1 = counter10_in;
        st_nxt.c10_s2 = st_r.c10_s1;
        st_nxt.c10_d = st_r.c10_s2;
        st_nxt.rdata = '0;
        // Internal count clock as an enable pulse from the divider
        if (st_r.div == 8'(INT_DIV - 1)) begin
            st_nxt.div = 8'h00;
            int_tick = 1'b1;
        end else begin
            st_nxt.div = st_r.div + 8'h01;
        end
        c10_edge = st_r.c10_s2 & ~st_r.c10_d;
        for (int i = 0; i < NUM_CNT; i++) begin
            st_nxt.prev_d[i] = st_r.ch[i].out;
            case (st_r.ch[i].clk_sel)
                CLK_EXT: tick = st_r.eclk_s2[i] & ~st_r.eclk_d[i];
                CLK_PREV: tick = (i == 0) ? 1'b0 :
                    (st_r.ch[(i+NUM_CNT-1)%NUM_CNT].out & ~st_r.prev_d[(i+NUM_CNT-1)%NUM_CNT]);
                CLK_INT: tick = int_tick;
                CLK_C10: tick = c10_edge;
                default: tick = 1'b0;
            endcase
            st_nxt.ch[i].gate_d = st_r.gate_s2[i];
            gate_rise = st_r.gate_s2[i] & ~st_r.ch[i].gate_d;
            nxt = pic_dec(st_r.ch[i].count, st_r.ch[i].dec);
            case (st_r.ch[i].mode)
                OP_MODE0: begin
                    if (tick && st_r.ch[i].running && st_r.gate_s2[i]) begin
                        st_nxt.ch[i].count = nxt;
                        if (nxt == 16'h0000) begin
                            st_nxt.ch[i].out = 1'b1;
                            st_nxt.ch[i].running = 1'b0;
                        end
                    end
                end
                OP_MODE1: begin
                    // low from the count clock after a gate rise
                    if (tick && st_r.trig[i]) begin
                        st_nxt.ch[i].count = pic_full(st_r.ch[i].reload, st_r.ch[i].dec);
                        st_nxt.ch[i].out = 1'b0;
                        st_nxt.ch[i].running = 1'b1;
                        st_nxt.trig[i] = 1'b0;
                    end else if (tick && st_r.ch[i].running) begin
                        st_nxt.ch[i].count = nxt;
                        if (nxt == 16'h0000) begin
                            st_nxt.ch[i].out = 1'b1;
                            st_nxt.ch[i].running = 1'b0;
                        end
                    end
                    // Set after the load, so a retrigger in that cycle is kept
                    if (gate_rise && st_r.ch[i].armed) begin
                        st_nxt.trig[i] = 1'b1;
                    end
                end
                OP_MODE2: begin
                    if (tick && st_r.gate_s2[i]) begin
                        st_nxt.ch[i].out = 1'b1;
                        st_nxt.ch[i].count = nxt;
                        if (st_r.ch[i].count == 16'h0001) begin
                            // reload in the low clock keeps the period equal to the count
                            st_nxt.ch[i].count = pic_full(st_r.ch[i].reload, st_r.ch[i].dec);
                            st_nxt.ch[i].out = 1'b0;
                        end
                    end
                end
                OP_MODE3: begin
                    if (tick && st_r.gate_s2[i]) begin
                        if (st_r.ch[i].count <= 16'h0002) begin
                            // reload each half; odd counts lose one clock in the low half
                            nxt = pic_full(st_r.ch[i].reload, st_r.ch[i].dec);
                            if (!st_r.ch[i].half) begin
                                nxt[0] = 1'b0;
                            end
                            st_nxt.ch[i].count = nxt;
                            st_nxt.ch[i].out = st_r.ch[i].half;
                            st_nxt.ch[i].half = ~st_r.ch[i].half;
                        end else begin
                            // Two steps per clock, so each half of an even count lasts half the count
                            st_nxt.ch[i].count = pic_dec(nxt, st_r.ch[i].dec);
                        end
                    end
                end
                OP_MODE4, OP_MODE5: begin
                    if (st_r.ch[i].mode == OP_MODE5 && gate_rise && st_r.ch[i].armed) begin
                        st_nxt.ch[i].count = pic_full(st_r.ch[i].reload, st_r.ch[i].dec);
                        st_nxt.ch[i].running = 1'b1;
                    end else if (tick && !st_r.ch[i].out) begin
                        st_nxt.ch[i].out = 1'b1;
                    end else if (tick && st_r.ch[i].running &&
                                 (st_r.ch[i].mode == OP_MODE5 || st_r.gate_s2[i])) begin
                        st_nxt.ch[i].count = nxt;
                        if (nxt == 16'h0000) begin
                            st_nxt.ch[i].out = 1'b0;
                            st_nxt.ch[i].running = 1'b0;
                        end
                    end
                end
                default: st_nxt.ch[i] = st_r.ch[i];
            endcase
        end
        if (reg_wr && reg_addr != READBACK_OFF) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (reg_addr == 4'(4 * i)) begin
                    op = reg_wdata[F_OP_LSB +: 3];
                    st_nxt.ch[i].dec = reg_wdata[F_DEC_BIT];
                    st_nxt.ch[i].clk_sel = reg_wdata[F_CLKSEL_LSB +: 2];
                    case (op)
                        OP_READ: begin
                            st_nxt.rb = st_r.ch[i].count;
                        end
                        OP_RESET: begin
                            st_nxt.ch[i] = '0;
                            st_nxt.ch[i].out = 1'b1;
                            st_nxt.ch[i].gate_d = st_r.gate_s2[i];
                            st_nxt.trig[i] = 1'b0;
                        end
                        default: begin
                            st_nxt.ch[i].mode = op;
                            st_nxt.ch[i].reload = reg_wdata[F_COUNT_LSB +: CNT_W];
                            st_nxt.ch[i].count = pic_full(reg_wdata[F_COUNT_LSB +: CNT_W],
                                reg_wdata[F_DEC_BIT]);
                            st_nxt.ch[i].armed = 1'b1;
                            st_nxt.trig[i] = 1'b0;
                            st_nxt.ch[i].half = 1'b0;
                            // mode 0 output low at once
                            st_nxt.ch[i].out = (op != OP_MODE0);
                            st_nxt.ch[i].running = (op == OP_MODE0) || (op == OP_MODE4);
                        end
                    endcase
                end
            end
        end
        if (reg_rd) begin
            case (reg_addr)
                CTRL0_OFF, CTRL1_OFF, CTRL2_OFF: begin
                    for (int i = 0; i < NUM_CNT; i++) begin
                        if (reg_addr == 4'(4 * i)) begin
                            st_nxt.rdata = {8'h00, 1'b0, st_r.ch[i].out, st_r.ch[i].clk_sel,
                                st_r.ch[i].dec, st_r.ch[i].mode, st_r.ch[i].count};
                        end
                    end
                end
                READBACK_OFF: st_nxt.rdata = {16'h0000, st_r.rb};
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            // Outputs idle high, so no false edge for the previous-output clock
            st_r.prev_d <= '1;
            for (int i = 0; i < NUM_CNT; i++) begin
                st_r.ch[i].out <= 1'b1;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            counter_output[i] = st_r.ch[i].out;
        end
    end

    assign reg_rdata = st_r.rdata;
endmodule : pic_counter
`default_nettype wire

/* pic_pkg.sv */
// Package for the programmable interval counter: widths, codes, offsets.
// Assumes a single 100 MHz core clock and a plain strobe register port.
package pic_pkg;
    localparam int NUM_CNT = 3;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    typedef enum logic [2:0] {
        OP_MODE0 = 3'h0,
        OP_MODE1 = 3'h1,
        OP_MODE2 = 3'h2,
        OP_MODE3 = 3'h3,
        OP_MODE4 = 3'h4,
        OP_MODE5 = 3'h5,
        OP_READ = 3'h6,
        OP_RESET = 3'h7
    } pic_op_e;

    // Register map: one word per counter, plus a read-back holding register
    localparam logic [ADDR_W-1:0] CTRL0_OFF = 4'h0;
    localparam logic [ADDR_W-1:0] CTRL1_OFF = 4'h4;
    localparam logic [ADDR_W-1:0] CTRL2_OFF = 4'h8;
    localparam logic [ADDR_W-1:0] READBACK_OFF = 4'hC;

    // Control word fields
    localparam int F_COUNT_LSB = 0;
    localparam int F_OP_LSB = 16;
    localparam int F_DEC_BIT = 19;
    localparam int F_CLKSEL_LSB = 20;

    localparam logic [2:0] OP_RST_VAL = 3'h0;
    localparam logic [1:0] CLKSEL_RST_VAL = 2'h0;
    localparam logic [CNT_W-1:0] COUNT_RST_VAL = 16'h0000;

    localparam logic [1:0] CLK_EXT = 2'h0;
    localparam logic [1:0] CLK_PREV = 2'h1;
    localparam logic [1:0] CLK_INT = 2'h2;
    localparam logic [1:0] CLK_C10 = 2'h3;

    localparam real CORE_CLK_MHZ = 100.0;
    localparam real INT_CLK_MHZ = 10.0;
    localparam int INT_DIV = int'(CORE_CLK_MHZ / INT_CLK_MHZ);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic [2:0] mode;
        logic [1:0] clk_sel;
        logic dec;
        logic out;
        logic armed;
        logic running;
        logic half;
        logic gate_d;
    } pic_chan_s;
endpackage : pic_pkg

/* pic_counter_assertions.sv */
// Port checker for the three-channel interval counter.
// Assumes it is bound to pic_counter; counter 0 carries the mode checks.
`timescale 1ns/1ns
`default_nettype none
module pic_counter_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [pic_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pic_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pic_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [pic_pkg::NUM_CNT-1:0] gate_in,
    input wire logic [pic_pkg::NUM_CNT-1:0] external_count_clock,
    input wire logic counter10_in,
    input wire logic [pic_pkg::NUM_CNT-1:0] counter_output
);
    import pic_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic wr0;
    logic [2:0] op0;
    logic m0_r;
    logic m0_nxt;
    assign wr0 = reg_wr && reg_addr == CTRL0_OFF;
    assign op0 = reg_wdata[F_OP_LSB +: 3];
    // Read-latch op leaves the mode alone
    always_comb begin
        m0_nxt = m0_r;
        if (wr0 && op0 != OP_READ) begin
            m0_nxt = op0 == OP_MODE0;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            m0_r <= 1'b0;
        end else begin
            m0_r <= m0_nxt;
        end
    end
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == '0) else $error("read data not idle");
    a_reset_out: assert property (
        $rose(rst_n) |-> counter_output == 3'h7) else $error("outputs not high after reset");
    a_mode0_low: assert property (
        wr0 && op0 == OP_MODE0 |=> !counter_output[0]) else $error("mode 0 output not low");
    a_mode4_high: assert property (
        wr0 && op0 == OP_MODE4 |=> counter_output[0][*2]) else $error("mode 4 output not high");
    a_reset_op_high: assert property (
        wr0 && op0 == OP_RESET |=> counter_output[0][*3]) else $error("reset op output low");
    a_mode_field: assert property (
        wr0 && op0 < 3'h6 ##2 reg_rd && reg_addr == CTRL0_OFF
        |=> reg_rdata[18:16] == $past(reg_wdata[18:16], 3)) else $error("mode field wrong");
    a_stat_out: assert property (
        reg_rd && reg_addr == CTRL0_OFF |=> reg_rdata[22] == $past(counter_output[0]))
        else $error("status output bit wrong");
    a_mode0_stay: assert property (
        m0_r && counter_output[0] && !wr0 |=> counter_output[0]) else $error("mode 0 high lost");
endmodule : pic_counter_assertions
`default_nettype wire

/* pic_counter_tb_top.sv */
// Self-checking bench for the three-channel interval counter.
// Assumes pic_pkg, pic_counter and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module pic_counter_tb_top;
    import pic_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [NUM_CNT-1:0] gate_in = '0;
    logic [NUM_CNT-1:0] ext_clk = '0;
    logic c10_clk = 1'b0;
    logic [NUM_CNT-1:0] counter_output;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] acc;
    int error_cnt = 0;
    int n_tests = 0;
    int n;
    int c;
    always #5 core_clk = ~core_clk;
    pic_counter dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .gate_in(gate_in), .external_count_clock(ext_clk), .counter10_in(c10_clk),
        .counter_output(counter_output));
    function automatic logic [DATA_W-1:0] cw(input int cnt, input int op, input bit dec = 0,
        input int cs = 0);
        cw = '0;
        cw[F_COUNT_LSB +: 16] = cnt[15:0];
        cw[F_OP_LSB +: 3] = op[2:0];
        cw[F_DEC_BIT] = dec;
        cw[F_CLKSEL_LSB +: 2] = cs[1:0];
    endfunction : cw
    function automatic logic [ADDR_W-1:0] off(input int ch);
        off = ADDR_W'(ch * 4);
    endfunction : off
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // One count clock: 4 cycles high, 4 low, so synced edges have landed
    task automatic tick(input int ch, input int k);
        repeat (k) begin
            @(posedge core_clk);
            c10_clk <= (ch == NUM_CNT);
            if (ch < NUM_CNT) begin
                ext_clk[ch] <= 1'b1;
            end
            repeat (4) @(posedge core_clk);
            c10_clk <= 1'b0;
            ext_clk <= '0;
            repeat (4) @(posedge core_clk);
        end
        #1;
    endtask : tick
    task automatic chk_w(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_w
    task automatic chk_o(input logic g, input logic e);
        chk_w({31'h0, g}, {31'h0, e});
    endtask : chk_o
    task automatic wrap_up;
        $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // Whole run is under a thousand cycles
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        n = $urandom(94);
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        for (c = 0; c < NUM_CNT; c++) chk_o(counter_output[c], 1'b1);
        rd(off(0));
        chk_w(d & 32'h0047_0000, 32'h0040_0000);
        gate_in <= 3'h7;
        wr(off(0), cw(16'h0010, 0, 1));
        @(posedge core_clk);
        #1 chk_o(counter_output[0], 1'b0);
        tick(0, 1);
        rd(off(0));
        chk_w({16'h0, d[15:0]}, 32'h9);
        gate_in[0] <= 1'b0;
        repeat (3) @(posedge core_clk);
        tick(0, 2);
        rd(off(0));
        chk_w({16'h0, d[15:0]}, 32'h9);
        gate_in[0] <= 1'b1;
        tick(0, 8);
        chk_o(counter_output[0], 1'b0);
        tick(0, 1);
        chk_o(counter_output[0], 1'b1);
        tick(0, 2);
        chk_o(counter_output[0], 1'b1);
        for (int i = 0; i < 4; i++) begin
            c = 1 + i % 2;
            n = 2 + $urandom % 6;
            wr(off(c), cw(n, 0));
            tick(c, n - 1);
            chk_o(counter_output[c], 1'b0);
            tick(c, 1);
            chk_o(counter_output[c], 1'b1);
            chk_o(counter_output[0], 1'b1);
        end
        n = 2 + $urandom % 16'hFFF0;
        wr(off(1), cw(n, 0));
        tick(1, 1);
        wr(off(1), cw(0, 6));
        rd(READBACK_OFF);
        chk_w({16'h0, d[15:0]}, n - 1);
        wr(off(0), cw(2, 4));
        tick(0, 1);
        chk_o(counter_output[0], 1'b1);
        tick(0, 1);
        chk_o(counter_output[0], 1'b0);
        tick(0, 1);
        chk_o(counter_output[0], 1'b1);
        wr(off(0), cw(0, 7));
        rd(off(0));
        chk_w(d & 32'h0047_0000, 32'h0040_0000);
        // periodic modes load 2 or more
        wr(off(1), cw(3, 2));
        for (int k = 1; k <= 7; k++) begin
            tick(1, 1);
            chk_o(counter_output[1], (k % 3) != 0);
        end
        wr(off(2), cw(4, 3));
        acc = '0;
        repeat (8) begin
            tick(2, 1);
            acc += counter_output[2];
        end
        chk_w(acc, 4);
        gate_in[0] <= 1'b0;
        wr(off(0), cw(3, 1));
        repeat (3) @(posedge core_clk);
        gate_in[0] <= 1'b1;
        tick(0, 2);
        chk_o(counter_output[0], 1'b0);
        tick(0, 2);
        chk_o(counter_output[0], 1'b1);
        gate_in[0] <= 1'b0;
        wr(off(0), cw(2, 5));
        tick(0, 3);
        chk_o(counter_output[0], 1'b1);
        gate_in[0] <= 1'b1;
        acc = '0;
        repeat (4) begin
            tick(0, 1);
            acc += !counter_output[0];
        end
        chk_w(acc, 1);
        for (int m = 0; m < 6; m++) begin
            wr(off(0), cw(5, m));
            rd(off(0));
            chk_w(d & 32'h0007_0000, m << 16);
        end
        // internal, counter 10 and previous-output clocks
        gate_in <= 3'h7;
        wr(off(2), cw(5, 0, 0, CLK_INT));
        repeat (35) @(posedge core_clk);
        #1 chk_o(counter_output[2], 1'b0);
        repeat (30) @(posedge core_clk);
        #1 chk_o(counter_output[2], 1'b1);
        wr(off(0), cw(3, 0, 0, CLK_C10));
        tick(NUM_CNT, 2);
        chk_o(counter_output[0], 1'b0);
        tick(NUM_CNT, 1);
        chk_o(counter_output[0], 1'b1);
        wr(off(1), cw(2, 0, 0, CLK_PREV));
        wr(off(0), cw(2, 2, 0, CLK_INT));
        repeat (5) @(posedge core_clk);
        #1 chk_o(counter_output[1], 1'b0);
        repeat (80) @(posedge core_clk);
        #1 chk_o(counter_output[1], 1'b1);
        rd(4'h2);
        chk_w(d, 32'h0);
        wrap_up();
    end
endmodule : pic_counter_tb_top
bind pic_counter pic_counter_assertions chk_u (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gate_in(gate_in), .external_count_clock(external_count_clock),
    .counter10_in(counter10_in), .counter_output(counter_output));
`default_nettype wire
